// >>> shared/adc_error_formula_select_pkg.sv
/*
  Shared constants and carriers of the converter computation control block.
  Assumes a 32-bit AHB-Lite register bus; register indices times four are byte addresses.
*/
package adc_error_formula_select_pkg;
  localparam int RES_W = 12;
  localparam int ACC_W = 20;
  localparam int ERR_W = 22;
  localparam int THR_W = 16;
  localparam int IDX_W = 10;

  // ============================================================
  // register indices (byte address = index * 4)
  localparam logic [IDX_W-1:0] IDX_RUN = 10'h111;
  localparam logic [IDX_W-1:0] IDX_PHASE = 10'h112;
  localparam logic [IDX_W-1:0] IDX_FILTER = 10'h113;
  localparam logic [IDX_W-1:0] IDX_THRESH = 10'h114;
  localparam logic [IDX_W-1:0] IDX_SETPT = 10'h116;
  localparam logic [IDX_W-1:0] IDX_UTH = 10'h117;
  localparam logic [IDX_W-1:0] IDX_LTH = 10'h118;
  localparam logic [IDX_W-1:0] IDX_RPT = 10'h119;
  localparam logic [IDX_W-1:0] IDX_FILTER_VALUE = 10'h11a;
  localparam logic [IDX_W-1:0] IDX_ERR = 10'h11b;
  localparam logic [IDX_W-1:0] IDX_ACC = 10'h11c;
  localparam logic [IDX_W-1:0] IDX_PREV = 10'h11d;
  localparam logic [IDX_W-1:0] IDX_RES = 10'h11e;
  localparam logic [IDX_W-1:0] IDX_IRQ = 10'h11f;
  localparam logic [IDX_W-1:0] IDX_MASK = 10'h120;

  // ============================================================
  // field positions and reset values
  localparam int RUN_ON = 7;
  localparam int RUN_REPEAT_CONVERSION = 6;
  localparam int RUN_GO = 0;
  localparam int PH_PRECHARGE_POLARITY = 7;
  localparam int PH_INVERTED_PRECHARGE_ENABLE = 6;
  localparam int PH_GUARD_POLARITY = 5;
  localparam int PH_DOUBLE_SAMPLE_ENABLE = 0;
  localparam int FM_PREVIOUS_SOURCE_SELECT = 7;
  localparam int FM_CRS = 4;
  localparam int FM_ACCUMULATOR_CLEAR = 3;
  localparam int FM_MD = 0;
  localparam int TC_ERROR_FORMULA_SELECT = 4;
  localparam int TC_SOI = 3;
  localparam int TC_TMD = 0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_THR = 1;
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [7:0] PHASE_MASK = 8'he1;
  localparam logic [7:0] THRESH_MASK = 8'h7f;

  // ============================================================
  // encodings
  localparam logic [2:0] MD_BASIC = 3'h0;
  localparam logic [2:0] MD_ACCUM = 3'h1;
  localparam logic [2:0] MD_AVG = 3'h2;
  localparam logic [2:0] MD_BURST = 3'h3;
  localparam logic [2:0] MD_LPF = 3'h4;
  localparam logic [2:0] ERROR_FORMULA_SELECT_DIFF = 3'h0;
  localparam logic [2:0] ERROR_FORMULA_SELECT_SETPT = 3'h1;
  localparam logic [2:0] ERROR_FORMULA_SELECT_FILT = 3'h2;
  localparam logic [2:0] ERROR_FORMULA_SELECT_PREVF = 3'h4;
  localparam logic [2:0] ERROR_FORMULA_SELECT_FSET = 3'h5;

  typedef struct packed {
    logic start;
    logic second;
    logic pin_short_en;
    logic hold_short_en;
    logic precharge_high;
    logic guard_high;
  } front_ctl_s;

  typedef struct packed {
    logic signed [ERR_W-1:0] result;
    logic signed [ERR_W-1:0] prev;
    logic signed [ERR_W-1:0] filter;
    logic signed [ERR_W-1:0] setpt;
    logic signed [ERR_W-1:0] uth;
    logic signed [ERR_W-1:0] lth;
    logic double_sample_enable;
    logic [2:0] error_formula_select;
    logic [2:0] threshold_irq_mode;
  } error_formula_select_in_s;
endpackage

// >>> tb/adc_computation_control_test.sv
/*
  Self-checking bench for the converter computation control block, with an integer model.
  Assumes the zero-wait AHB-Lite slave and the conversion handshake of the design.
*/
`timescale 1ns/1ps
module adc_computation_control_test import adc_error_formula_select_pkg::*;;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, v, w;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic conv_done = 0, pre_time_nonzero = 0, input_is_internal = 0;
  logic [RES_W-1:0] conv_data = 0;
  front_ctl_s front_ctl;
  logic [IDX_W-1:0] ridx[6] = '{IDX_RUN, IDX_PHASE, IDX_FILTER, IDX_THRESH, IDX_IRQ, IDX_MASK};
  int calcs[6] = '{0, 1, 2, 4, 5, 3};
  int num_errors = 0, checks_done = 0;
  int r, p, f, s, u, l, sum, ds, previous_source_select, shift_select, md, error_formula_select, threshold_irq_mode, precharge_polarity, guard_polarity, inverted_precharge_enable, nb, tally, repeat_count, stop_on_threshold;
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  adc_computation_control u_adc_computation_control (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_done(conv_done), .conv_data(conv_data),
    .pre_time_nonzero(pre_time_nonzero), .input_is_internal(input_is_internal), .front_ctl(front_ctl), .irq(irq));

  // ============================================================
  // reporting and bus tasks
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic wait_ready();
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hready === 1'b1) return;
    end
    num_errors++;
    complete_run();
  endtask
  // an idle edge first, so no strobe is driven twice in one time step
  task automatic ahb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'h0};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    ahb(1'b1, idx, d, v);
  endtask
  task automatic rdc(input string n, input logic [IDX_W-1:0] idx, input logic [31:0] e);
    ahb(1'b0, idx, 32'h0, v);
    chk(n, e, v);
  endtask

  // ============================================================
  // model
  function automatic int dev();
    case (error_formula_select)
      0: return r - p;
      1: return ds ? r - p - s : r - s;
      2: return ds ? r - p - f : r - f;
      4: return p - f;
      5: return f - s;
      default: return 0;
    endcase
  endfunction
  function automatic int thr(input int e);
    case (threshold_irq_mode)
      7: return 1;
      6: return e > u;
      5: return e <= u;
      4: return e < l || e > u;
      3: return e > l && e < u;
      2: return e >= l;
      1: return e < l;
      default: return 0;
    endcase
  endfunction
  // one accumulated sample; average and burst restart once rpt samples are in
  task automatic acc_step(input int x);
    if (md == 4) begin
      sum = sum + x - (sum >> shift_select);
      f = sum >> shift_select;
    end else if (md != 0) begin
      sum += x;
      tally++;
      if (md == 1) begin
        f = sum >> shift_select;
      end else if (tally >= repeat_count) begin
        f = sum >> shift_select;
        sum = 0;
        tally = 0;
      end
    end
  endtask
  task automatic trig(input int repeat_conversion, input int dsv, input logic [11:0] d0, input logic [11:0] d1);
    int e;
    int h;
    ds = dsv;
    precharge_polarity = $urandom % 2;
    guard_polarity = $urandom % 2;
    inverted_precharge_enable = $urandom % 2;
    pre_time_nonzero <= 1'($urandom);
    input_is_internal <= 1'($urandom);
    wr(IDX_PHASE, 32'(precharge_polarity << 7 | inverted_precharge_enable << 6 | guard_polarity << 5 | ds));
    wr(IDX_RUN, 32'(repeat_conversion << 6 | 'h81));
    p = previous_source_select ? f & 'hfff : r;
    for (int k = 0; k <= ds + nb; k++) begin
      for (e = 0; front_ctl.start !== 1'b1; e++) begin
        if (e == 200) begin
          num_errors++;
          complete_run();
        end
        @(negedge hclk);
      end
      @(negedge hclk);
      chk("precharge", precharge_polarity ^ (inverted_precharge_enable & ds & k), front_ctl.precharge_high);
      chk("guard", guard_polarity ^ (inverted_precharge_enable & ds & k), front_ctl.guard_high);
      chk("pin short", pre_time_nonzero && !input_is_internal, front_ctl.pin_short_en);
      chk("hold short", pre_time_nonzero && input_is_internal, front_ctl.hold_short_en);
      chk("second", ds & k, front_ctl.second);
      @(posedge hclk);
      conv_done <= 1'b1;
      conv_data <= k ? d1 : d0;
      @(posedge hclk);
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
    end
    if (ds) p = d0;
    r = (ds || nb) ? d1 : d0;
    if (nb) acc_step(d0);
    acc_step(r);
    e = dev();
    h = thr(e);
    repeat (6) @(posedge hclk);
    chk("irq pin", h, irq);
    rdc("result", IDX_RES, r);
    rdc("earlier", IDX_PREV, p);
    rdc("filter", IDX_FILTER_VALUE, f);
    rdc("deviation", IDX_ERR, e & 'h3fffff);
    rdc("irq status", IDX_IRQ, 32'(h << 1 | 1));
    rdc("run", IDX_RUN, 32'(repeat_conversion << 6 | 'h80 | (repeat_conversion && !(stop_on_threshold && h))));
    chk("irq cleared", 0, irq);
  endtask

  // ============================================================
  // main sequence
  initial begin
    void'($urandom(46));
    {r, p, f, sum, previous_source_select, error_formula_select, threshold_irq_mode, nb, tally, stop_on_threshold} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ridx[i]) rdc("reset value", ridx[i], 0);
    rdc("unmapped", 10'h3ff, 0);
    w = $urandom;
    wr(IDX_PHASE, w);
    rdc("phase", IDX_PHASE, w & 32'he1);
    s = $urandom % 64;
    u = 40;
    l = -40;
    wr(IDX_SETPT, s);
    wr(IDX_UTH, {16'h0, 16'(u)});
    wr(IDX_LTH, {16'h0, 16'(l)});
    wr(IDX_MASK, 32'h2);
    // accumulate with a shift, so the filter value becomes nonzero
    shift_select = 1;
    md = 1;
    wr(IDX_FILTER, 32'h11);
    for (int i = 0; i < 6; i++) trig(0, i > 2, 12'($urandom % 256), 12'($urandom % 256));
    wr(IDX_FILTER, 32'h19);
    repeat (2) @(posedge hclk);
    rdc("acc clear", IDX_ACC, 0);
    rdc("clear bit", IDX_FILTER, 32'h11);
    sum = 0;
    tally = 0;
    // two-sample average, two-sample burst, then the low-pass filter
    repeat_count = 2;
    wr(IDX_RPT, repeat_count);
    for (int i = 0; i < 6; i++) begin
      md = 2 + i / 2;
      nb = md == 3;
      wr(IDX_FILTER, 32'(shift_select << 4 | md));
      trig(0, 0, 12'($urandom % 256), 12'($urandom % 256));
    end
    nb = 0;
    md = 0;
    for (int i = 0; i < 24; i++) begin
      error_formula_select = calcs[i % 6];
      threshold_irq_mode = i % 8;
      previous_source_select = $urandom % 2;
      wr(IDX_FILTER, 32'(previous_source_select << 7));
      wr(IDX_THRESH, 32'(error_formula_select << 4 | threshold_irq_mode));
      trig(0, $urandom % 2, 12'($urandom % 256), 12'($urandom % 256));
    end
    error_formula_select = 0;
    threshold_irq_mode = 7;
    stop_on_threshold = 1;
    wr(IDX_THRESH, 32'h0f);
    trig(1, 0, 12'h5, 12'h9);
    // no stop on threshold: go stays set and the next trigger starts
    stop_on_threshold = 0;
    wr(IDX_THRESH, 32'h07);
    trig(1, 0, 12'h5, 12'h9);
    wr(IDX_RUN, 32'h0);
    rdc("stopped", IDX_RUN, 0);
    complete_run();
  end
endmodule

// >>> verilog/adc_computation_control.sv
/*
  Converter computation control: sequencing, precharge/guard polarity, accumulator and
  filter, deviation and threshold interrupt, AHB-Lite register slave.
  Assumes the analog front end starts a conversion on front_ctl.start and returns one
  conv_done pulse with conv_data; all inputs synchronous to hclk.
*/
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module adc_computation_control import adc_error_formula_select_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_data,
  input wire logic pre_time_nonzero,
  input wire logic input_is_internal,
  output front_ctl_s front_ctl,
  output logic irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ERROR_FORMULA_SELECT, ST_DONE} seq_e;

  seq_e state_ff;
  logic [7:0] run_ff, phase_ff, filt_ff, thr_ff, rpt_ff, mask_ff;
  logic [1:0] irq_stat_ff;
  logic [THR_W-1:0] setpt_ff, uth_ff, lth_ff;
  logic [RES_W-1:0] result_ff, prev_ff;
  logic [ACC_W-1:0] acc_ff, filter_ff;
  logic [7:0] tally_ff;
  logic ov_ff, second_ff, start_ff, thr_hit_ff;
  logic [ERR_W-1:0] err_ff;
  logic wr_pend_ff;
  logic [IDX_W-1:0] wr_idx_ff;
  logic [31:0] hrdata_ff;

  // ============================================================
  // field views
  logic on, repeat_conversion, go, precharge_polarity, inverted_precharge_enable, guard_polarity, double_sample_enable, previous_source_select, accumulator_clear, stop_on_threshold;
  logic [2:0] shift_select, md, error_formula_select, threshold_irq_mode;
  assign on = run_ff[RUN_ON];
  assign repeat_conversion = run_ff[RUN_REPEAT_CONVERSION];
  assign go = run_ff[RUN_GO];
  assign precharge_polarity = phase_ff[PH_PRECHARGE_POLARITY];
  assign inverted_precharge_enable = phase_ff[PH_INVERTED_PRECHARGE_ENABLE];
  assign guard_polarity = phase_ff[PH_GUARD_POLARITY];
  assign double_sample_enable = phase_ff[PH_DOUBLE_SAMPLE_ENABLE];
  assign previous_source_select = filt_ff[FM_PREVIOUS_SOURCE_SELECT];
  assign shift_select = filt_ff[FM_CRS+:3];
  assign accumulator_clear = filt_ff[FM_ACCUMULATOR_CLEAR];
  assign md = filt_ff[FM_MD+:3];
  assign error_formula_select = thr_ff[TC_ERROR_FORMULA_SELECT+:3];
  assign stop_on_threshold = thr_ff[TC_SOI];
  assign threshold_irq_mode = thr_ff[TC_TMD+:3];

  function automatic logic signed [ERR_W-1:0] sext_thr(input logic [THR_W-1:0] v);
    sext_thr = {{(ERR_W-THR_W){v[THR_W-1]}}, v};
  endfunction

  // ============================================================
  // bus slave: zero wait states, read data captured in the address phase
  logic addr_ok, rd_take, wr_data, last_sample, burst_more, accum_mode, retrig;
  logic [IDX_W-1:0] a_idx;
  logic [31:0] rd_mux;
  assign a_idx = haddr[IDX_W+1:2];
  assign addr_ok = hsel && htrans[1] && hready;
  assign rd_take = addr_ok && !hwrite;
  assign wr_data = wr_pend_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_comb begin
    unique case (a_idx)
      IDX_RUN: rd_mux = 32'(run_ff);
      IDX_PHASE: rd_mux = 32'(phase_ff);
      IDX_FILTER: rd_mux = 32'(filt_ff);
      IDX_THRESH: rd_mux = 32'(thr_ff);
      IDX_SETPT: rd_mux = 32'(setpt_ff);
      IDX_UTH: rd_mux = 32'(uth_ff);
      IDX_LTH: rd_mux = 32'(lth_ff);
      IDX_RPT: rd_mux = 32'(rpt_ff);
      IDX_FILTER_VALUE: rd_mux = 32'(filter_ff);
      IDX_ERR: rd_mux = 32'(err_ff);
      IDX_ACC: rd_mux = {ov_ff, 3'h0, tally_ff, acc_ff};
      IDX_PREV: rd_mux = 32'(prev_ff);
      IDX_RES: rd_mux = 32'(result_ff);
      IDX_IRQ: rd_mux = 32'(irq_stat_ff);
      IDX_MASK: rd_mux = 32'(mask_ff);
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= '0;
      hrdata_ff <= 32'h0;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      if (addr_ok)
        wr_idx_ff <= a_idx;
      if (rd_take)
        hrdata_ff <= rd_mux;
    end
  end

  // ============================================================
  // plain software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= REG8_RESET;
      setpt_ff <= '0;
      uth_ff <= '0;
      lth_ff <= '0;
      rpt_ff <= REG8_RESET;
      mask_ff <= REG8_RESET;
    end else if (wr_data) begin
      unique case (wr_idx_ff)
        IDX_PHASE: phase_ff <= hwdata[7:0] & PHASE_MASK;
        IDX_SETPT: setpt_ff <= hwdata[THR_W-1:0];
        IDX_UTH: uth_ff <= hwdata[THR_W-1:0];
        IDX_LTH: lth_ff <= hwdata[THR_W-1:0];
        IDX_RPT: rpt_ff <= hwdata[7:0];
        IDX_MASK: mask_ff <= {6'h0, hwdata[1:0]};
        default: ;
      endcase
    end
  end

  // mode/threshold control; the clear command self-clears on the same edge at which it clears the accumulator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_ff <= REG8_RESET;
      thr_ff <= REG8_RESET;
    end else begin
      if (wr_data && wr_idx_ff == IDX_FILTER)
        filt_ff <= hwdata[7:0];
      else if (accumulator_clear)
        filt_ff[FM_ACCUMULATOR_CLEAR] <= 1'b0;
      if (wr_data && wr_idx_ff == IDX_THRESH)
        thr_ff <= hwdata[7:0] & THRESH_MASK;
    end
  end

  // run bit: a software write wins over the hardware clear in the same cycle
  assign retrig = repeat_conversion && !(stop_on_threshold && thr_hit_ff);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      run_ff <= REG8_RESET;
    else if (wr_data && wr_idx_ff == IDX_RUN)
      run_ff <= {hwdata[7:6], 5'h0, hwdata[0]};
    else if (state_ff == ST_DONE && !retrig)
      run_ff[RUN_GO] <= 1'b0;
  end

  // ============================================================
  // conversion sequencer
  assign accum_mode = (md == MD_ACCUM) || (md == MD_AVG) || (md == MD_BURST) || (md == MD_LPF);
  assign burst_more = (md == MD_BURST) && (8'(tally_ff + 8'h1) < rpt_ff);
  assign last_sample = conv_done && !(double_sample_enable && !second_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      second_ff <= 1'b0;
      start_ff <= 1'b0;
      prev_ff <= '0;
      result_ff <= '0;
    end else begin
      start_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          if (go && on) begin
            prev_ff <= previous_source_select ? filter_ff[RES_W-1:0] : result_ff;
            second_ff <= 1'b0;
            start_ff <= 1'b1;
            state_ff <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (!go || !on) begin
            state_ff <= ST_IDLE;
          end else if (conv_done) begin
            result_ff <= conv_data;
            if (double_sample_enable && !second_ff) begin
              prev_ff <= conv_data;
              second_ff <= 1'b1;
              start_ff <= 1'b1;
            end else if (burst_more) begin
              second_ff <= 1'b0;
              start_ff <= 1'b1;
            end else begin
              state_ff <= ST_ERROR_FORMULA_SELECT;
            end
          end
        end
        ST_ERROR_FORMULA_SELECT: state_ff <= go ? ST_DONE : ST_IDLE;
        ST_DONE: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ============================================================
  // accumulator and filter; lpf keeps the sum at 2^crs times the filter value
  logic [ACC_W:0] acc_sum;
  logic [ACC_W-1:0] sample_ext, acc_lpf, acc_shr;
  assign sample_ext = ACC_W'(conv_data);
  assign acc_sum = {1'b0, acc_ff} + {1'b0, sample_ext};
  assign acc_shr = acc_ff >> shift_select;
  assign acc_lpf = ACC_W'(acc_ff + sample_ext - acc_shr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= '0;
      tally_ff <= 8'h0;
      ov_ff <= 1'b0;
      filter_ff <= '0;
    end else if (accumulator_clear) begin
      acc_ff <= '0;
      tally_ff <= 8'h0;
      ov_ff <= 1'b0;
    end else if (state_ff == ST_CONV && last_sample && go && on && accum_mode) begin
      tally_ff <= 8'(tally_ff + 8'h1);
      if (md == MD_LPF) begin
        acc_ff <= acc_lpf;
        filter_ff <= acc_lpf >> shift_select;
      end else if ((md == MD_AVG || md == MD_BURST) && 8'(tally_ff + 8'h1) >= rpt_ff) begin
        filter_ff <= acc_sum[ACC_W-1:0] >> shift_select;
        acc_ff <= '0;
        tally_ff <= 8'h0;
        ov_ff <= ov_ff | acc_sum[ACC_W];
      end else begin
        acc_ff <= acc_sum[ACC_W-1:0];
        ov_ff <= ov_ff | acc_sum[ACC_W];
        if (md == MD_ACCUM)
          filter_ff <= acc_sum[ACC_W-1:0] >> shift_select;
      end
    end
  end

  // ============================================================
  // deviation and threshold, registered once per trigger
  error_formula_select_in_s cin;
  logic signed [ERR_W-1:0] err_w;
  logic hit_w;
  assign cin.result = ERR_W'(result_ff);
  assign cin.prev = ERR_W'(prev_ff);
  assign cin.filter = ERR_W'(filter_ff);
  assign cin.setpt = sext_thr(setpt_ff);
  assign cin.uth = sext_thr(uth_ff);
  assign cin.lth = sext_thr(lth_ff);
  assign cin.double_sample_enable = double_sample_enable;
  assign cin.error_formula_select = error_formula_select;
  assign cin.threshold_irq_mode = threshold_irq_mode;

  adc_deviation_error_formula_select u_error_formula_select (
    .cin(cin),
    .err(err_w),
    .err_ovf(),
    .above_upper(),
    .below_lower(),
    .thr_hit(hit_w)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_ff <= '0;
      thr_hit_ff <= 1'b0;
    end else if (state_ff == ST_ERROR_FORMULA_SELECT) begin
      err_ff <= err_w;
      thr_hit_ff <= hit_w;
    end
  end

  // ============================================================
  // interrupt status: read clears, a new event in the same cycle wins
  logic [1:0] irq_set;
  assign irq_set = {state_ff == ST_DONE && thr_hit_ff, state_ff == ST_DONE};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irq_stat_ff <= 2'h0;
    else if (rd_take && a_idx == IDX_IRQ)
      irq_stat_ff <= irq_set;
    else
      irq_stat_ff <= irq_stat_ff | irq_set;
  end
  assign irq = |(irq_stat_ff & mask_ff[1:0]);

  // ============================================================
  // front end controls; polarity flips only on the second half of a double sample
  logic flip;
  assign flip = inverted_precharge_enable && double_sample_enable && second_ff;
  assign front_ctl.start = start_ff;
  assign front_ctl.second = second_ff;
  assign front_ctl.pin_short_en = pre_time_nonzero && !input_is_internal && state_ff == ST_CONV;
  assign front_ctl.hold_short_en = pre_time_nonzero && input_is_internal && state_ff == ST_CONV;
  assign front_ctl.precharge_high = precharge_polarity ^ flip;
  assign front_ctl.guard_high = guard_polarity ^ flip;

  // ============================================================
  // checks
  AST_PRE_POL: assert property (@(posedge hclk) disable iff (!hresetn)
    !second_ff |-> front_ctl.precharge_high == precharge_polarity) else $error("precharge level wrong");
  AST_INVERT: assert property (@(posedge hclk) disable iff (!hresetn)
    (second_ff && double_sample_enable && inverted_precharge_enable) |-> (front_ctl.precharge_high != precharge_polarity && front_ctl.guard_high != guard_polarity))
    else $error("second conversion not inverted");
  AST_GUARD: assert property (@(posedge hclk) disable iff (!hresetn)
    (!inverted_precharge_enable || !second_ff) |-> front_ctl.guard_high == guard_polarity) else $error("guard level wrong");
  AST_DOUBLE: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == ST_CONV && conv_done && double_sample_enable && !second_ff && go && on) |=>
    (prev_ff == $past(conv_data) && start_ff && second_ff)) else $error("first sample not kept");
  AST_PREV_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == ST_IDLE && go && on) |=>
    prev_ff == ($past(previous_source_select) ? $past(filter_ff[RES_W-1:0]) : $past(result_ff))) else $error("earlier source");
  AST_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    accumulator_clear |=> (acc_ff == '0 && tally_ff == 8'h0 && !ov_ff)) else $error("clear incomplete");
  AST_CLEAR_DONE: assert property (@(posedge hclk) disable iff (!hresetn)
    (accumulator_clear && !wr_data) |=> !accumulator_clear) else $error("clear bit stuck");
  AST_BASIC_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (md == MD_BASIC && !accumulator_clear) |=> $stable(acc_ff)) else $error("basic mode accumulated");
  AST_DIFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == ST_DONE && error_formula_select == ERROR_FORMULA_SELECT_DIFF) |->
    err_ff == ERR_W'(ERR_W'(result_ff) - ERR_W'(prev_ff))) else $error("difference wrong");
  AST_ONESHOT: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == ST_DONE && !repeat_conversion && !(wr_data && wr_idx_ff == IDX_RUN)) |=> !go) else $error("run not cleared");
  AST_STOP_THR: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == ST_DONE && repeat_conversion && stop_on_threshold && thr_hit_ff && !(wr_data && wr_idx_ff == IDX_RUN)) |=> !go)
    else $error("stop on threshold failed");
  AST_ALWAYS_HIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == ST_ERROR_FORMULA_SELECT && threshold_irq_mode == 3'h7) |=> thr_hit_ff ##1 irq_stat_ff[IRQ_THR]) else $error("mode 111 no hit");
  AST_ERROR_FORMULA_SELECT_ORDER: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == ST_DONE |-> $past(state_ff) == ST_ERROR_FORMULA_SELECT) else $error("threshold before deviation");

  COV_DOUBLE: cover property (@(posedge hclk) disable iff (!hresetn) state_ff == ST_DONE && double_sample_enable);
  COV_LPF: cover property (@(posedge hclk) disable iff (!hresetn) state_ff == ST_DONE && md == MD_LPF);
  COV_RETRIG: cover property (@(posedge hclk) disable iff (!hresetn) state_ff == ST_DONE && retrig ##2 start_ff);
  COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn) irq && irq_stat_ff[IRQ_THR]);
endmodule

// >>> verilog/adc_deviation_error_formula_select.sv
/*
  Deviation arithmetic and threshold test, purely combinational.
  Assumes the caller registers err and thr_hit once per completed trigger.
*/
`timescale 1ns/1ps
module adc_deviation_error_formula_select import adc_error_formula_select_pkg::*; (
  input error_formula_select_in_s cin,
  output logic signed [ERR_W-1:0] err,
  output logic err_ovf,
  output logic above_upper,
  output logic below_lower,
  output logic thr_hit
);
  logic signed [ERR_W+1:0] base;
  logic signed [ERR_W+1:0] wide;

  function automatic logic signed [ERR_W+1:0] sx(input logic signed [ERR_W-1:0] v);
    sx = {{2{v[ERR_W-1]}}, v};
  endfunction

  // ============================================================
  // deviation formula
  always_comb begin
    base = cin.double_sample_enable ? sx(cin.result) - sx(cin.prev) : sx(cin.result);
    unique case (cin.error_formula_select)
      ERROR_FORMULA_SELECT_DIFF: wide = sx(cin.result) - sx(cin.prev);
      ERROR_FORMULA_SELECT_SETPT: wide = base - sx(cin.setpt);
      ERROR_FORMULA_SELECT_FILT: wide = base - sx(cin.filter);
      ERROR_FORMULA_SELECT_PREVF: wide = sx(cin.prev) - sx(cin.filter);
      ERROR_FORMULA_SELECT_FSET: wide = sx(cin.filter) - sx(cin.setpt);
      default: wide = '0;
    endcase
    err = wide[ERR_W-1:0];
    err_ovf = (wide[ERR_W+1:ERR_W-1] != 3'h0) && (wide[ERR_W+1:ERR_W-1] != 3'h7);
  end

  // ============================================================
  // threshold test
  always_comb begin
    above_upper = err > cin.uth;
    below_lower = err < cin.lth;
    unique case (cin.threshold_irq_mode)
      3'h7: thr_hit = 1'b1;
      3'h6: thr_hit = above_upper;
      3'h5: thr_hit = !above_upper;
      3'h4: thr_hit = below_lower || above_upper;
      3'h3: thr_hit = (err > cin.lth) && (err < cin.uth);
      3'h2: thr_hit = !below_lower;
      3'h1: thr_hit = below_lower;
      3'h0: thr_hit = 1'b0;
    endcase
  end
endmodule
